// File: logic/cie_pkg.sv
// Shared constants and types for the instruction execute subset block
package cie_pkg;

    // ************************************************
    // Register bus map
    // ************************************************
    localparam int         ADDR_W     = 8;
    localparam logic [7:0] REG_INSTR  = 8'h00;
    localparam logic [7:0] REG_ACCUM  = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_PC     = 8'h0C;
    localparam logic [7:0] REG_LATCH  = 8'h10;
    localparam logic [7:0] REG_FPTR   = 8'h14;
    localparam logic [7:0] REG_FDATA  = 8'h18;
    localparam logic [7:0] REG_STACK  = 8'h1C;

    // Status register bit positions
    localparam int ST_ZERO   = 0;
    localparam int ST_EXPIRY = 1;
    localparam int ST_SLEEP  = 2;
    localparam int ST_NOP    = 3;

    // ************************************************
    // Instruction word layout
    // ************************************************
    localparam int INSTR_W   = 14;
    localparam int PC_W      = 13;
    localparam int CLASS_HI  = 13;
    localparam int CLASS_LO  = 11;
    localparam int SUB_HI    = 10;
    localparam int SUB_LO    = 8;
    localparam int DEST_BIT  = 7;
    localparam int TARGET_HI = 10;
    localparam int LATCH_HI  = 4;
    localparam int LATCH_LO  = 3;

    localparam logic [2:0] CLS_GROUP = 3'h0;
    localparam logic [2:0] CLS_CALL  = 3'h4;
    localparam logic [2:0] CLS_JUMP  = 3'h5;

    localparam logic [2:0] SUB_RESTART = 3'h0;
    localparam logic [2:0] SUB_ZACC    = 3'h1;
    localparam logic [2:0] SUB_ZFILE   = 3'h2;
    localparam logic [2:0] SUB_INVERT  = 3'h3;
    localparam logic [2:0] SUB_MINUS   = 3'h4;
    localparam logic [2:0] SUB_CDSKIP  = 3'h5;

    // ************************************************
    // Reset values and timing
    // ************************************************
    localparam logic [7:0]  ACCUM_RST  = 8'h00;
    localparam logic [12:0] PC_RST     = 13'h0000;
    localparam logic [7:0]  LATCH_RST  = 8'h00;
    localparam logic        EXPIRY_RST = 1'b1;
    localparam logic        SLEEP_RST  = 1'b1;
    localparam int          PHASE_W    = 2;
    localparam logic [1:0]  PHASE_RDY  = 2'h2;
    localparam logic [1:0]  PHASE_LAST = 2'h3;

    typedef enum logic [1:0] {
        EX_IDLE = 2'b00,
        EX_RUN  = 2'b01,
        EX_DEAD = 2'b10
    } cie_exec_t;

    typedef enum logic [3:0] {
        OP_NOP     = 4'b0000,
        OP_RESTART = 4'b0001,
        OP_ZACC    = 4'b0010,
        OP_ZFILE   = 4'b0011,
        OP_INVERT  = 4'b0100,
        OP_MINUS   = 4'b0101,
        OP_CDSKIP  = 4'b0110,
        OP_CALL    = 4'b0111,
        OP_JUMP    = 4'b1000
    } cie_op_t;

endpackage

// File: logic/cie_file_mem.sv
// File register memory with one write port and two registered read ports
`timescale 1ns/1ps
module cie_file_mem #(
    parameter int DATA_W = 8,
    parameter int ADDR_W = 7
) (
    input  wire logic              clk,
    input  wire logic              we,
    input  wire logic [ADDR_W-1:0] waddr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic [ADDR_W-1:0] raddr_a,
    output logic      [DATA_W-1:0] rdata_a,
    input  wire logic [ADDR_W-1:0] raddr_b,
    output logic      [DATA_W-1:0] rdata_b
);

    typedef struct packed {
        logic [DATA_W-1:0] rd_a;
        logic [DATA_W-1:0] rd_b;
    } cie_mem_rd_t;

    logic [DATA_W-1:0] mem_q [2**ADDR_W];
    cie_mem_rd_t       rd_r;
    cie_mem_rd_t       rd_nxt;

    always_comb begin
        rd_nxt.rd_a = mem_q[raddr_a];
        rd_nxt.rd_b = mem_q[raddr_b];
    end

    // No reset: contents are undefined until written
    always_ff @(posedge clk) begin
        rd_r <= rd_nxt;
        if (we) begin
            mem_q[waddr] <= wdata;
        end
    end

    assign rdata_a = rd_r.rd_a;
    assign rdata_b = rd_r.rd_b;

endmodule

// File: logic/cie_core.sv
// Instruction execute subset with APB register access
//
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
// Function
// - Guard restart op clears the guard counter.
// - Guard restart op clears the guard prescaler in the same execution.
// - Guard restart op sets expiry and sleep entry flags, no operands.
// - Call pushes current program counter plus one onto the stack head.
// - Call loads 11-bit immediate into program counter bits 10 to 0.
// - Call takes counter bits 12 and 11 from latch bits 4 and 3.
// - Call takes two instruction cycles.
// - Invert op complements file, destination bit picks accumulator or file, zero updated.
// - Zero file op writes zero to the addressed file and sets zero.
// - Minus one op decrements file, routed by destination bit, zero updated.
// - Zero accumulator op clears accumulator and sets zero flag.
// - Countdown skip op decrements, routes by destination, leaves flags alone.
// - Countdown skip with zero result discards next fetch, runs two cycles.
// - Jump loads 11-bit immediate plus latch bits, two cycles.
module cie_core #(
    parameter int FILE_AW = 7
) (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [cie_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    output logic                            guard_clear,
    output logic                            prescale_clear,
    output logic                            stack_push,
    output logic      [12:0]                stack_data,
    output logic                            zero_flag,
    output logic                            expiry_flag,
    output logic                            sleep_entry_flag,
    output logic      [12:0]                pc_value
);

    // ************************************************
    // Parameter check
    // ************************************************
    if (FILE_AW < 1 || FILE_AW > 7) begin : g_bad_aw
        $error("FILE_AW must lie between 1 and 7");
    end

    // ************************************************
    // State
    // ************************************************
    typedef struct packed {
        logic [1:0]         phase;
        cie_pkg::cie_exec_t state;
        logic [13:0]        instr;
        logic [7:0]         accum;
        logic               zero;
        logic               expiry;
        logic               sleep;
        logic [12:0]        pc;
        logic [7:0]         latch;
        logic [6:0]         fptr;
        logic               guard_clr;
        logic               pre_clr;
        logic               push;
        logic [12:0]        stack;
        logic               pready;
        logic               pslverr;
        logic [31:0]        prdata;
    } cie_state_t;

    cie_state_t s_r;
    cie_state_t s_nxt;

    cie_pkg::cie_op_t   op;
    logic               commit;
    logic               two_cycle;
    logic               dest_file;
    logic [FILE_AW-1:0] faddr;
    logic [7:0]         file_rd;
    logic [7:0]         bus_rd;
    logic [7:0]         alu_res;
    logic [12:0]        pc_inc;
    logic [12:0]        branch_pc;
    logic               bus_acc;
    logic               bus_slot_ok;
    logic               mem_we;
    logic [FILE_AW-1:0] mem_waddr;
    logic [7:0]         mem_wdata;

    function automatic cie_pkg::cie_op_t cie_decode(input logic [13:0] w);
        cie_pkg::cie_op_t d;
        d = cie_pkg::OP_NOP;
        case (w[cie_pkg::CLASS_HI:cie_pkg::CLASS_LO])
            cie_pkg::CLS_CALL: begin
                d = cie_pkg::OP_CALL;
            end
            cie_pkg::CLS_JUMP: begin
                d = cie_pkg::OP_JUMP;
            end
            cie_pkg::CLS_GROUP: begin
                case (w[cie_pkg::SUB_HI:cie_pkg::SUB_LO])
                    cie_pkg::SUB_RESTART: d = cie_pkg::OP_RESTART;
                    cie_pkg::SUB_ZACC:    d = cie_pkg::OP_ZACC;
                    cie_pkg::SUB_ZFILE:   d = cie_pkg::OP_ZFILE;
                    cie_pkg::SUB_INVERT:  d = cie_pkg::OP_INVERT;
                    cie_pkg::SUB_MINUS:   d = cie_pkg::OP_MINUS;
                    cie_pkg::SUB_CDSKIP:  d = cie_pkg::OP_CDSKIP;
                    default:              d = cie_pkg::OP_NOP;
                endcase
            end
            default: begin
                d = cie_pkg::OP_NOP;
            end
        endcase
        return d;
    endfunction

    // ************************************************
    // Decode and datapath
    // ************************************************
    assign op        = cie_decode(s_r.instr);
    assign dest_file = s_r.instr[cie_pkg::DEST_BIT];
    assign faddr     = s_r.instr[FILE_AW-1:0];
    assign pc_inc    = s_r.pc + 13'h0001;
    assign branch_pc = {s_r.latch[cie_pkg::LATCH_HI:cie_pkg::LATCH_LO],
                        s_r.instr[cie_pkg::TARGET_HI:0]};
    assign commit    = (s_r.state == cie_pkg::EX_RUN) && (s_r.phase == cie_pkg::PHASE_LAST);
    assign bus_acc   = psel && penable;

    always_comb begin
        case (op)
            cie_pkg::OP_INVERT: alu_res = ~file_rd;
            cie_pkg::OP_ZFILE:  alu_res = 8'h00;
            default:            alu_res = file_rd - 8'h01;
        endcase
    end

    // Ops that burn a second cycle
    assign two_cycle = (s_r.state == cie_pkg::EX_RUN) &&
                       (op == cie_pkg::OP_CALL || op == cie_pkg::OP_JUMP ||
                        (op == cie_pkg::OP_CDSKIP && alu_res == 8'h00));

    // Instruction writes finish only at a cycle boundary; other writes avoid the commit edge
    assign bus_slot_ok = !pwrite ||
                         ((paddr == cie_pkg::REG_INSTR) ?
                          (s_r.phase == cie_pkg::PHASE_RDY && !two_cycle) :
                          (s_r.phase != cie_pkg::PHASE_RDY));

    // ************************************************
    // Next state
    // ************************************************
    always_comb begin
        s_nxt           = s_r;
        s_nxt.phase     = s_r.phase + 2'h1;
        s_nxt.guard_clr = 1'b0;
        s_nxt.pre_clr   = 1'b0;
        s_nxt.push      = 1'b0;
        s_nxt.pready    = 1'b0;
        s_nxt.pslverr   = 1'b0;
        mem_we          = 1'b0;
        mem_waddr       = faddr;
        mem_wdata       = alu_res;

        if (commit) begin
            // Single cycle unless branching or skipping
            s_nxt.state = two_cycle ? cie_pkg::EX_DEAD : cie_pkg::EX_IDLE;
            s_nxt.pc    = pc_inc;
            case (op)
                cie_pkg::OP_RESTART: begin
                    s_nxt.guard_clr = 1'b1;
                    s_nxt.pre_clr   = 1'b1;
                    s_nxt.expiry    = 1'b1;
                    s_nxt.sleep     = 1'b1;
                end
                cie_pkg::OP_ZACC: begin
                    s_nxt.accum = 8'h00;
                    s_nxt.zero  = 1'b1;
                end
                cie_pkg::OP_ZFILE: begin
                    mem_we     = 1'b1;
                    s_nxt.zero = 1'b1;
                end
                cie_pkg::OP_INVERT, cie_pkg::OP_MINUS: begin
                    mem_we     = dest_file;
                    s_nxt.zero = (alu_res == 8'h00);
                    if (!dest_file) begin
                        s_nxt.accum = alu_res;
                    end
                end
                cie_pkg::OP_CDSKIP: begin
                    mem_we = dest_file;
                    if (!dest_file) begin
                        s_nxt.accum = alu_res;
                    end
                    // Discarded fetch still advances the counter
                    if (alu_res == 8'h00) begin
                        s_nxt.pc = s_r.pc + 13'h0002;
                    end
                end
                cie_pkg::OP_CALL: begin
                    s_nxt.push  = 1'b1;
                    s_nxt.stack = pc_inc;
                    s_nxt.pc    = branch_pc;
                end
                cie_pkg::OP_JUMP: begin
                    s_nxt.pc = branch_pc;
                end
                default: begin
                    s_nxt.pc = pc_inc;
                end
            endcase
        end else if (s_r.state == cie_pkg::EX_DEAD && s_r.phase == cie_pkg::PHASE_LAST) begin
            s_nxt.state = cie_pkg::EX_IDLE;
        end

        // APB answer, one wait state at least
        if (bus_acc && !s_r.pready && bus_slot_ok) begin
            s_nxt.pready = 1'b1;
            s_nxt.prdata = 32'h00000000;
            case (paddr)
                cie_pkg::REG_INSTR:  s_nxt.prdata[13:0] = s_r.instr;
                cie_pkg::REG_ACCUM:  s_nxt.prdata[7:0]  = s_r.accum;
                cie_pkg::REG_STATUS: begin
                    s_nxt.prdata[cie_pkg::ST_ZERO]   = s_r.zero;
                    s_nxt.prdata[cie_pkg::ST_EXPIRY] = s_r.expiry;
                    s_nxt.prdata[cie_pkg::ST_SLEEP]  = s_r.sleep;
                    s_nxt.prdata[cie_pkg::ST_NOP]    = (s_r.state == cie_pkg::EX_DEAD);
                end
                cie_pkg::REG_PC:     s_nxt.prdata[12:0] = s_r.pc;
                cie_pkg::REG_LATCH:  s_nxt.prdata[7:0]  = s_r.latch;
                cie_pkg::REG_FPTR:   s_nxt.prdata[6:0]  = s_r.fptr;
                cie_pkg::REG_FDATA:  s_nxt.prdata[7:0]  = bus_rd;
                cie_pkg::REG_STACK:  s_nxt.prdata[12:0] = s_r.stack;
                default:             s_nxt.pslverr      = 1'b1;
            endcase
            if (pwrite) begin
                s_nxt.prdata = 32'h00000000;
            end
        end

        // Writes take effect on the completing edge only
        if (bus_acc && s_r.pready && pwrite && !s_r.pslverr) begin
            case (paddr)
                cie_pkg::REG_INSTR: begin
                    s_nxt.state = cie_pkg::EX_RUN;
                    s_nxt.instr = pwdata[13:0];
                end
                cie_pkg::REG_ACCUM: s_nxt.accum = pwdata[7:0];
                cie_pkg::REG_STATUS: begin
                    s_nxt.zero   = pwdata[cie_pkg::ST_ZERO];
                    s_nxt.expiry = pwdata[cie_pkg::ST_EXPIRY];
                    s_nxt.sleep  = pwdata[cie_pkg::ST_SLEEP];
                end
                cie_pkg::REG_PC:    s_nxt.pc    = pwdata[12:0];
                cie_pkg::REG_LATCH: s_nxt.latch = pwdata[7:0];
                cie_pkg::REG_FPTR:  s_nxt.fptr  = pwdata[6:0];
                cie_pkg::REG_FDATA: begin
                    mem_we    = 1'b1;
                    mem_waddr = s_r.fptr[FILE_AW-1:0];
                    mem_wdata = pwdata[7:0];
                end
                default: begin
                    s_nxt.stack = s_r.stack;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r           <= '0;
            s_r.state     <= cie_pkg::EX_IDLE;
            s_r.accum     <= cie_pkg::ACCUM_RST;
            s_r.pc        <= cie_pkg::PC_RST;
            s_r.latch     <= cie_pkg::LATCH_RST;
            s_r.expiry    <= cie_pkg::EXPIRY_RST;
            s_r.sleep     <= cie_pkg::SLEEP_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ************************************************
    // File memory
    // ************************************************
    cie_file_mem #(
        .DATA_W (8),
        .ADDR_W (FILE_AW)
    ) u_file (
        .clk     (pclk),
        .we      (mem_we),
        .waddr   (mem_waddr),
        .wdata   (mem_wdata),
        .raddr_a (faddr),
        .rdata_a (file_rd),
        .raddr_b (s_r.fptr[FILE_AW-1:0]),
        .rdata_b (bus_rd)
    );

    assign prdata           = s_r.prdata;
    assign pready           = s_r.pready;
    assign pslverr          = s_r.pslverr;
    assign guard_clear      = s_r.guard_clr;
    assign prescale_clear   = s_r.pre_clr;
    assign stack_push       = s_r.push;
    assign stack_data       = s_r.stack;
    assign zero_flag        = s_r.zero;
    assign expiry_flag      = s_r.expiry;
    assign sleep_entry_flag = s_r.sleep;
    assign pc_value         = s_r.pc;

    // ************************************************
    // Checks
    // ************************************************
    default clocking cb_chk @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_guard_strobe: assert property (
        commit && op == cie_pkg::OP_RESTART |=> guard_clear ##1 !guard_clear)
        else $error("guard clear strobe missing");
    chk_prescale_pair: assert property (
        guard_clear |-> prescale_clear && $past(commit))
        else $error("prescaler clear not paired");
    chk_restart_flags: assert property (
        commit && op == cie_pkg::OP_RESTART |=> expiry_flag && sleep_entry_flag)
        else $error("restart flags not set");
    chk_call_push: assert property (
        commit && op == cie_pkg::OP_CALL |=>
        stack_push && stack_data == $past(s_r.pc) + 13'h0001)
        else $error("call return address wrong");
    chk_branch_target: assert property (
        commit && (op == cie_pkg::OP_CALL || op == cie_pkg::OP_JUMP) |=>
        pc_value == $past(branch_pc) && zero_flag == $past(s_r.zero))
        else $error("branch target wrong");
    chk_branch_dead: assert property (
        commit && (op == cie_pkg::OP_CALL || op == cie_pkg::OP_JUMP) |=>
        (s_r.state == cie_pkg::EX_DEAD && pc_value == $past(branch_pc, 2))[*4])
        else $error("branch not two cycles");
    chk_invert_acc: assert property (
        commit && op == cie_pkg::OP_INVERT && !dest_file |=> s_r.accum == ~$past(file_rd))
        else $error("invert result wrong");
    chk_zero_file: assert property (
        commit && op == cie_pkg::OP_ZFILE |-> mem_we && mem_wdata == 8'h00 ##1 zero_flag)
        else $error("zero file op wrong");
    chk_minus_acc: assert property (
        commit && op == cie_pkg::OP_MINUS && !dest_file |=>
        s_r.accum == $past(file_rd) - 8'h01)
        else $error("decrement result wrong");
    chk_zero_accum: assert property (
        commit && op == cie_pkg::OP_ZACC |=> s_r.accum == 8'h00 && zero_flag)
        else $error("accumulator clear wrong");
    chk_skip_flags: assert property (
        commit && op == cie_pkg::OP_CDSKIP |=>
        $stable(zero_flag) && $stable(expiry_flag) && $stable(sleep_entry_flag))
        else $error("countdown changed flags");
    chk_skip_taken: assert property (
        commit && op == cie_pkg::OP_CDSKIP && alu_res == 8'h00 |=>
        pc_value == $past(s_r.pc) + 13'h0002 && s_r.state == cie_pkg::EX_DEAD)
        else $error("taken skip wrong");
    chk_single_cycle: assert property (
        commit && !two_cycle |=> s_r.state != cie_pkg::EX_DEAD)
        else $error("single cycle op stalled");
    chk_zero_follow: assert property (
        commit && (op == cie_pkg::OP_INVERT || op == cie_pkg::OP_MINUS) |=>
        zero_flag == ($past(alu_res) == 8'h00))
        else $error("zero flag mismatch");

endmodule

// File: dv/tb_cpu_instruction_execute_subset.sv
// Self-checking bench for the instruction execute subset block
`timescale 1ns/1ps
module tb_cpu_instruction_execute_subset;
    logic        pclk, presetn, psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rv;
    logic        pready, pslverr, guard_clear, prescale_clear, stack_push, ev;
    logic        zero_flag, expiry_flag, sleep_entry_flag;
    logic [12:0] stack_data, pc_value;
    int          fail_count, n_checks, cyc, gcnt, scnt, t0, i;
    typedef struct {
        logic [2:0] sub; logic d; logic [6:0] f; logic [7:0] fv, acc;
        logic z0; logic [7:0] ea, ef; logic ez;
    } cie_row_t;
    cie_row_t rows[8] = '{
        '{3'h3, 1'b0, 7'h7F, 8'hA5, 8'h00, 1'b1, 8'h5A, 8'hA5, 1'b0},
        '{3'h3, 1'b1, 7'h01, 8'hFF, 8'h33, 1'b0, 8'h33, 8'h00, 1'b1},
        '{3'h2, 1'b1, 7'h02, 8'h77, 8'h11, 1'b0, 8'h11, 8'h00, 1'b1},
        '{3'h4, 1'b0, 7'h03, 8'h01, 8'h55, 1'b0, 8'h00, 8'h01, 1'b1},
        '{3'h4, 1'b1, 7'h04, 8'h00, 8'h22, 1'b1, 8'h22, 8'hFF, 1'b0},
        '{3'h1, 1'b0, 7'h05, 8'h12, 8'h9C, 1'b0, 8'h00, 8'h12, 1'b1},
        '{3'h5, 1'b1, 7'h06, 8'h05, 8'h00, 1'b1, 8'h00, 8'h04, 1'b1},
        '{3'h5, 1'b0, 7'h06, 8'h80, 8'h00, 1'b0, 8'h7F, 8'h80, 1'b0}};
    logic [13:0] bw[3] = '{14'h27FE, 14'h2801, 14'h0586};
    logic [7:0]  bl[3] = '{8'h18, 8'h08, 8'h00};
    logic [12:0] bp[3] = '{13'h1FFF, 13'h0802, 13'h0126};

    cie_core uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .guard_clear(guard_clear), .prescale_clear(prescale_clear),
        .stack_push(stack_push), .stack_data(stack_data), .zero_flag(zero_flag),
        .expiry_flag(expiry_flag), .sleep_entry_flag(sleep_entry_flag), .pc_value(pc_value));

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Request held until the edge that samples pready high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 40; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (k == 40) begin
            fail_count++;
            test_done();
        end else begin
            rv = prdata; ev = pslverr; psel <= 1'b0; penable <= 1'b0;
        end
    endtask

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (guard_clear) gcnt <= gcnt + 1;
        if (stack_push) scnt <= scnt + 1;
        if (guard_clear || prescale_clear) check(prescale_clear, guard_clear);
    end

    initial begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        test_done();
    end

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {fail_count, n_checks, cyc, gcnt, scnt} = '0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, cie_pkg::REG_STATUS, 32'h0);
        check({expiry_flag, sleep_entry_flag, zero_flag}, 3'b110);
        check(rv, 32'h6);
        check(pc_value, 13'h0000);
        $display("reset test done");
        for (i = 0; i < 8; i++) begin
            apb(1'b1, cie_pkg::REG_FPTR, {25'h0, rows[i].f});
            apb(1'b1, cie_pkg::REG_FDATA, {24'h0, rows[i].fv});
            apb(1'b1, cie_pkg::REG_ACCUM, {24'h0, rows[i].acc});
            apb(1'b1, cie_pkg::REG_STATUS, {31'h0, rows[i].z0});
            apb(1'b1, cie_pkg::REG_PC, 32'h100);
            apb(1'b1, cie_pkg::REG_INSTR, {18'h0, 3'h0, rows[i].sub, rows[i].d, rows[i].f});
            repeat (6) @(posedge pclk);
            check(zero_flag, rows[i].ez);
            apb(1'b0, cie_pkg::REG_ACCUM, 32'h0);
            check(rv, {24'h0, rows[i].ea});
            apb(1'b0, cie_pkg::REG_FDATA, 32'h0);
            check(rv, {24'h0, rows[i].ef});
            check(pc_value, 13'h0101);
            $display("row %0d done", i);
        end
        apb(1'b1, cie_pkg::REG_STATUS, 32'h0);
        t0 = gcnt;
        apb(1'b1, cie_pkg::REG_INSTR, 32'h0);
        repeat (6) @(posedge pclk);
        check(gcnt, t0 + 1);
        check({expiry_flag, sleep_entry_flag}, 2'b11);
        $display("restart test done");
        // Call, jump and taken countdown skip: gap to next accept shows the extra cycle
        for (i = 0; i < 3; i++) begin
            apb(1'b1, cie_pkg::REG_LATCH, {24'h0, bl[i]});
            apb(1'b1, cie_pkg::REG_PC, 32'h123);
            apb(1'b1, cie_pkg::REG_FDATA, 32'h1);
            apb(1'b1, cie_pkg::REG_STATUS, 32'h1);
            apb(1'b1, cie_pkg::REG_INSTR, {18'h0, bw[i]});
            t0 = cyc;
            apb(1'b1, cie_pkg::REG_INSTR, 32'h0700);
            check(cyc - t0, 8);
            repeat (6) @(posedge pclk);
            check(pc_value, bp[i]);
            check(zero_flag, 1'b1);
            $display("branch %0d done", i);
        end
        check(stack_data, 13'h0124);
        check(scnt, 1);
        apb(1'b0, cie_pkg::REG_FDATA, 32'h0);
        check(rv, 32'h0);
        apb(1'b0, cie_pkg::REG_STACK, 32'h0);
        check(rv, 32'h124);
        apb(1'b0, 8'h20, 32'h0);
        check(ev, 1'b1);
        check(rv, 32'h0);
        $display("bus test done");
        // Mid-run reset brings expiry and sleep flags back to one, zero flag, counter and stack to zero
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        check({expiry_flag, sleep_entry_flag, zero_flag}, 3'b110);
        check(stack_data, 13'h0000);
        check(pc_value, 13'h0000);
        presetn <= 1'b1;
        apb(1'b0, cie_pkg::REG_STATUS, 32'h0);
        check(rv, 32'h6);
        $display("mid-run reset test done");
        test_done();
    end
endmodule
